/* File: core/clk_range_regs.sv */
// Clock tuning, fullscale range, reference, timestamp and lane register bank
`timescale 1ns/1ps
`default_nettype none
`include "clk_range_regs_defines.svh"

module clk_range_regs #(
  parameter int POS_W = 24                  // Capture position width
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire clk_range_regs_pkg::cfg_req_t     cfg_req,
  output var  clk_range_regs_pkg::cfg_rsp_t     cfg_rsp,
  input  wire logic                             capture_valid,
  input  wire logic [POS_W-1:0]                 sysref_edge_position,
  output var  clk_range_regs_pkg::analog_ctrl_t analog_ctrl
);
  import clk_range_regs_pkg::*;

  // Stored registers
  logic [7:0]       tune_reg;       // Sampling clock tuning
  logic [15:0]      fsa_reg;        // Input A fullscale code
  logic [15:0]      fsb_reg;        // Input B fullscale code
  logic [7:0]       refsel_reg;     // Reference source select
  logic [7:0]       tstamp_reg;     // Timestamp input control
  logic [7:0]       preemph_reg;    // Serializer pre-emphasis
  logic [POS_W-1:0] pos_reg;        // Captured SYSREF position

  // Address decode
  wire logic wr        = cfg_req.wr_en;
  wire logic [14:0] a  = cfg_req.addr;
  wire logic hit_tune  = (a == `ADDR_TUNE);
  wire logic hit_pos0  = (a == `ADDR_POS_0);
  wire logic hit_pos1  = (a == `ADDR_POS_1);
  wire logic hit_pos2  = (a == `ADDR_POS_2);
  wire logic hit_fsa0  = (a == `ADDR_FSA_0);
  wire logic hit_fsa1  = (a == `ADDR_FSA_1);
  wire logic hit_fsb0  = (a == `ADDR_FSB_0);
  wire logic hit_fsb1  = (a == `ADDR_FSB_1);
  wire logic hit_ref   = (a == `ADDR_REFSEL);
  wire logic hit_ts    = (a == `ADDR_TSTAMP);
  wire logic hit_pe    = (a == `ADDR_PREEMPH);
  wire logic hit_any   = hit_tune | hit_pos0 | hit_pos1 | hit_pos2 |
                         hit_fsa0 | hit_fsa1 | hit_fsb0 | hit_fsb1 |
                         hit_ref  | hit_ts   | hit_pe;

  // Read data selection, position is read-only
  wire logic [7:0] rd_sel =
    hit_tune ? tune_reg :
    hit_pos0 ? pos_reg[7:0] :
    hit_pos1 ? pos_reg[15:8] :
    hit_pos2 ? pos_reg[23:16] :
    hit_fsa0 ? fsa_reg[7:0] :
    hit_fsa1 ? fsa_reg[15:8] :
    hit_fsb0 ? fsb_reg[7:0] :
    hit_fsb1 ? fsb_reg[15:8] :
    hit_ref  ? refsel_reg :
    hit_ts   ? tstamp_reg :
    hit_pe   ? preemph_reg : 8'h00;

  // Tuning register, whole byte stored including reserved bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tune_reg <= `RST_TUNE;
    end else if (wr && hit_tune) begin
      tune_reg <= cfg_req.wdata;
    end
  end

  // Fullscale codes, byte-wise, each input separate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fsa_reg <= `RST_FULLSCALE;
      fsb_reg <= `RST_FULLSCALE;
    end else begin
      if (wr && hit_fsa0) fsa_reg[7:0]  <= cfg_req.wdata;
      if (wr && hit_fsa1) fsa_reg[15:8] <= cfg_req.wdata;
      if (wr && hit_fsb0) fsb_reg[7:0]  <= cfg_req.wdata;
      if (wr && hit_fsb1) fsb_reg[15:8] <= cfg_req.wdata;
    end
  end

  // Reference, timestamp and pre-emphasis registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refsel_reg  <= `RST_REFSEL;
      tstamp_reg  <= `RST_TSTAMP;
      preemph_reg <= `RST_PREEMPH;
    end else begin
      if (wr && hit_ref) refsel_reg  <= cfg_req.wdata;
      if (wr && hit_ts)  tstamp_reg  <= cfg_req.wdata;
      if (wr && hit_pe)  preemph_reg <= cfg_req.wdata;
    end
  end

  // Capture position, held until the next capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg <= `RST_POSITION;
    end else if (capture_valid) begin
      pos_reg <= sysref_edge_position;
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.rvalid <= cfg_req.rd_en;
      cfg_rsp.hit    <= cfg_req.rd_en & hit_any;
      cfg_rsp.rdata  <= cfg_req.rd_en ? rd_sel : 8'h00;
    end
  end

  // Analog controls, only documented bits drive them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.feedback_high_gain       <= tune_reg[`BIT_FB_GAIN];
      analog_ctrl.supply_noise_suppress_en <=
        tune_reg[`BIT_NOISE_SUPPR];
      analog_ctrl.sample_clock_delay       <=
        tune_reg[`BIT_DELAY_HI:`BIT_DELAY_LO];
      analog_ctrl.input_a_fullscale        <= fsa_reg;
      analog_ctrl.input_b_fullscale        <= fsb_reg;
      analog_ctrl.reference_bypass         <=
        refsel_reg[`BIT_REF_BYPASS];
      analog_ctrl.timestamp_receiver_en    <= tstamp_reg[`BIT_TS_RECV];
      analog_ctrl.timestamp_pecl_mode      <= tstamp_reg[`BIT_TS_PECL];
      analog_ctrl.lane_preemphasis         <=
        preemph_reg[`BIT_PE_HI:`BIT_PE_LO];
      analog_ctrl.lane_preemphasis_boost   <=
        preemph_reg[`BIT_PE_BOOST];
    end
  end

endmodule : clk_range_regs
`default_nettype wire

/* File: shared/clk_range_regs_defines.svh */
// Register offsets, reset values and field positions for the bank
//
// Contract
// - Tuning register resets 0x11; bit4 high gain
// - Tuning bit2 enables supply noise suppression
// - Tuning bits 1:0 one-hot delay, reset one
// - Tuning reserved bits 7:5, 3 reset zero
// - Report 24-bit read-only SYSREF edge position
// - Input A fullscale code, resets 0xA000
// - Input B fullscale code, independent, resets 0xA000
// - Reference select bit0 picks supply reference
// - Timestamp control bit0 enables receiver
// - Timestamp control bit1 selects PECL mode
// - Timestamp control resets zero, bits 7:2 reserved
// - Pre-emphasis bits 2:0 common to 16 lanes
// - Pre-emphasis bit3 adds boost
// - Pre-emphasis register resets zero, bits 7:4 reserved
`ifndef CLK_RANGE_REGS_DEFINES_SVH
`define CLK_RANGE_REGS_DEFINES_SVH

// Byte addresses on the configuration port
`define ADDR_TUNE        15'h002B
`define ADDR_POS_0       15'h002C
`define ADDR_POS_1       15'h002D
`define ADDR_POS_2       15'h002E
`define ADDR_FSA_0       15'h0030
`define ADDR_FSA_1       15'h0031
`define ADDR_FSB_0       15'h0032
`define ADDR_FSB_1       15'h0033
`define ADDR_REFSEL      15'h0038
`define ADDR_TSTAMP      15'h003B
`define ADDR_PREEMPH     15'h0048

// Reset values
`define RST_TUNE         8'h11
`define RST_FULLSCALE    16'hA000
`define RST_REFSEL       8'h00
`define RST_TSTAMP       8'h00
`define RST_PREEMPH      8'h00
`define RST_POSITION     24'h000000

// Field positions
`define BIT_FB_GAIN      4
`define BIT_NOISE_SUPPR  2
`define BIT_DELAY_HI     1
`define BIT_DELAY_LO     0
`define BIT_REF_BYPASS   0
`define BIT_TS_RECV      0
`define BIT_TS_PECL      1
`define BIT_PE_BOOST     3
`define BIT_PE_HI        2
`define BIT_PE_LO        0

`endif

/* File: shared/clk_range_regs_pkg.sv */
// Types shared by the clock, range and serializer register bank
package clk_range_regs_pkg;

  // Configuration port access from the serial front end
  typedef struct packed {
    logic        wr_en;   // One-cycle write strobe
    logic        rd_en;   // One-cycle read strobe
    logic [14:0] addr;    // Byte address
    logic [7:0]  wdata;   // Write byte
  } cfg_req_t;

  // Read answer toward the serial front end
  typedef struct packed {
    logic       rvalid;   // One-cycle read answer strobe
    logic       hit;      // Address belonged to this bank
    logic [7:0] rdata;    // Read byte
  } cfg_rsp_t;

  // Settings driven into the analog and serializer circuits
  typedef struct packed {
    logic        feedback_high_gain;
    logic        supply_noise_suppress_en;
    logic [1:0]  sample_clock_delay;
    logic [15:0] input_a_fullscale;
    logic [15:0] input_b_fullscale;
    logic        reference_bypass;
    logic        timestamp_receiver_en;
    logic        timestamp_pecl_mode;
    logic [2:0]  lane_preemphasis;
    logic        lane_preemphasis_boost;
  } analog_ctrl_t;

endpackage : clk_range_regs_pkg

/* File: verif/clk_range_regs_assertions.sv */
// Port property checks for the clock, range and lane register bank
`timescale 1ns/1ps
`default_nettype none
module clk_range_regs_assertions import clk_range_regs_pkg::*; #(
  parameter int POS_W = 24  // Capture position width
) (
  input wire logic                             clk,
  input wire logic                             rst_b,
  input wire clk_range_regs_pkg::cfg_req_t     cfg_req,
  input wire clk_range_regs_pkg::cfg_rsp_t     cfg_rsp,
  input wire logic                             capture_valid,
  input wire logic [POS_W-1:0]                 sysref_edge_position,
  input wire clk_range_regs_pkg::analog_ctrl_t analog_ctrl
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic         wr = cfg_req.wr_en;   // Write strobe
  wire logic [14:0]  ad = cfg_req.addr;    // Byte address
  wire analog_ctrl_t c  = analog_ctrl;     // Short alias
  logic [7:0]        d1;                   // Write byte, one edge late
  logic [7:0]        d2;                   // Write byte, two edges late
  localparam analog_ctrl_t RST = '{1'b1, 1'b0, 2'h1, 16'hA000, 16'hA000,
    1'b0, 1'b0, 1'b0, 3'h0, 1'b0};
  // Delay line so a field can be tied to the byte that set it
  always_ff @(posedge clk) begin
    d1 <= cfg_req.wdata;
    d2 <= d1;
  end
  a_reset_ctrl: assert property ($rose(rst_b) |=> c == RST)
    else $error("control outputs wrong after reset");
  a_tune_apply: assert property (wr && ad == 15'h002B |-> ##2
    {c.feedback_high_gain, c.supply_noise_suppress_en, c.sample_clock_delay}
    == {d2[4], d2[2], d2[1:0]}) else $error("tuning fields not applied");
  a_fsa_low: assert property (wr && ad == 15'h0030 |-> ##2
    c.input_a_fullscale[7:0] == d2) else $error("input a range low byte");
  a_fsb_high: assert property (wr && ad == 15'h0033 |-> ##2
    c.input_b_fullscale[15:8] == d2) else $error("input b range high byte");
  a_ref_apply: assert property (wr && ad == 15'h0038 |-> ##2
    c.reference_bypass == d2[0]) else $error("reference select not applied");
  a_stamp_apply: assert property (wr && ad == 15'h003B |-> ##2
    {c.timestamp_pecl_mode, c.timestamp_receiver_en} == d2[1:0])
    else $error("timestamp controls not applied");
  a_lane_apply: assert property (wr && ad == 15'h0048 |-> ##2
    {c.lane_preemphasis_boost, c.lane_preemphasis} == d2[3:0])
    else $error("lane pre-emphasis not applied");
  a_pos_answer: assert property (cfg_req.rd_en && ad == 15'h002C |=>
    cfg_rsp.rvalid && cfg_rsp.hit) else $error("position read unanswered");
  cover property (cfg_req.rd_en && ad == 15'h0050);
  cover property (capture_valid);
  cover property (wr && ad == 15'h0048);
endmodule : clk_range_regs_assertions
bind clk_range_regs clk_range_regs_assertions #(.POS_W(POS_W)) u_chk (
  .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
  .capture_valid(capture_valid), .sysref_edge_position(sysref_edge_position),
  .analog_ctrl(analog_ctrl));
`default_nettype wire

/* File: verif/clk_range_regs_test.sv */
// Self-checking bench for the clock, range and lane register bank
`timescale 1ns/1ps
`default_nettype none
module clk_range_regs_test;
  import clk_range_regs_pkg::*;
  logic         clk = 1'b0;   // 40 MHz clock
  logic         rst_b = 1'b0; // Reset, active low
  cfg_req_t     req = '0;     // Port request
  cfg_rsp_t     rsp;          // Port answer
  logic         cap = 1'b0;   // Capture pulse
  logic [23:0]  pos = '0;     // Capture value
  analog_ctrl_t ctrl;         // Control outputs
  int           mismatches = 0;
  int           checks_done = 0;
  localparam logic [14:0] WA [8] = '{15'h002B, 15'h0030, 15'h0031,
    15'h0032, 15'h0033, 15'h0038, 15'h003B, 15'h0048};
  localparam logic [7:0] WD [8] = '{8'hEE, 8'h00, 8'h20, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFD};
  localparam logic [7:0] RD [8] = '{8'h11, 8'h00, 8'hA0, 8'h00, 8'hA0,
    8'h00, 8'h00, 8'h00};
  always #12.5 clk = ~clk;
  clk_range_regs dut (.clk(clk), .rst_b(rst_b), .cfg_req(req),
    .cfg_rsp(rsp), .capture_valid(cap), .sysref_edge_position(pos),
    .analog_ctrl(ctrl));
  task results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // Whole control word is 43 bits wide
  task cmp(input logic [42:0] got, input logic [42:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask : wr
  // Read one byte; answer must come one edge after the strobe
  task rd(input logic [14:0] a, input logic [8:0] e);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1;
    if (rsp.rvalid !== 1'b1) begin
      mismatches++;
      results();
    end
    cmp({rsp.hit, rsp.rdata}, e);
  endtask : rd
  task t_reset();
    @(posedge clk) #1;
    cmp(ctrl, {1'b1, 1'b0, 2'h1, 32'hA000A000, 7'h00});
    for (int i = 0; i < 8; i++) rd(WA[i], {1'b1, RD[i]});
    rd(15'h0050, 9'h000);
    $display("reset test done");
  endtask : t_reset
  task t_writes();
    for (int i = 0; i < 8; i++) wr(WA[i], WD[i]);
    @(posedge clk) #1;
    cmp(ctrl, {1'b0, 1'b1, 2'h2, 32'h2000FFFF, 7'h7B});
    for (int i = 0; i < 8; i++) rd(WA[i], {1'b1, WD[i]});
    $display("write test done");
  endtask : t_writes
  task t_codes();
    for (int v = 0; v < 16; v++) begin
      wr(15'h0048, v[7:0]);
      @(posedge clk) #1;
      cmp({ctrl.lane_preemphasis_boost, ctrl.lane_preemphasis}, v);
    end
    $display("lane code test done");
  endtask : t_codes
  task t_position();
    @(posedge clk) {cap, pos} <= {1'b1, 24'hABCDEF};
    @(posedge clk) {cap, pos} <= {1'b0, 24'h123456};
    wr(15'h002C, 8'h00);
    rd(15'h002C, 9'h1EF);
    rd(15'h002D, 9'h1CD);
    rd(15'h002E, 9'h1AB);
    $display("position test done");
  endtask : t_position
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_writes();
    t_codes();
    t_position();
    results();
  end
endmodule : clk_range_regs_test
`default_nettype wire
